// ### common/rx_filter_pkg.sv
// package: register map, fields and constants of the receive frame filter
package rx_filter_pkg;
  localparam logic [11:0] filter_off = 12'h03c;
  localparam logic [11:0] status_off = 12'h040;
  localparam logic [7:0] filter_reset = 8'h0f;
  localparam int ver_hi = 7;
  localparam int ver_lo = 6;
  localparam int promisc_bit = 5;
  localparam int rsv_bit = 4;
  localparam int cmd_bit = 3;
  localparam int ack_bit = 2;
  localparam int pay_bit = 1;
  localparam int bcn_bit = 0;
  localparam logic [1:0] sel_any = 2'h0;
  localparam logic [1:0] sel_v0 = 2'h1;
  localparam logic [1:0] sel_v1 = 2'h2;
  localparam logic [1:0] sel_v01 = 2'h3;
  localparam logic [2:0] ft_beacon = 3'h0;
  localparam logic [2:0] ft_data = 3'h1;
  localparam logic [2:0] ft_ack = 3'h2;
  localparam logic [2:0] ft_cmd = 3'h3;
  localparam logic [6:0] len_min = 7'h05;
  localparam logic [6:0] len_max = 7'h7f;
  localparam int fcf_type_lo = 0;
  localparam int fcf_ver_lo = 12;
  localparam int fcf_sec_bit = 3;
endpackage : rx_filter_pkg

// ### src/version_check.sv
// version selector comparison
`timescale 1ns/1ns
module version_check
  import rx_filter_pkg::*;
(
  input wire logic [1:0] sel, // version selector
  input wire logic [1:0] ver, // frame version field
  output logic pass // version acceptable
);
  always_comb begin
    case (sel)
      sel_any: pass = 1'b1;
      sel_v0: pass = (ver == 2'h0);
      sel_v1: pass = (ver == 2'h1);
      sel_v01: pass = (ver == 2'h0) || (ver == 2'h1);
      default: pass = 1'b0;
    endcase
  end
endmodule : version_check

// ### src/type_check.sv
// frame type enable check
`timescale 1ns/1ns
module type_check
  import rx_filter_pkg::*;
(
  input wire logic [7:0] cfg, // sampled filter register
  input wire logic [2:0] ftype, // frame type field
  output logic type_ok, // type enabled
  output logic reserved // type is a reserved value
);
  always_comb begin
    reserved = 1'b0;
    case (ftype)
      ft_beacon: type_ok = cfg[bcn_bit];
      ft_data: type_ok = cfg[pay_bit];
      ft_ack: type_ok = cfg[ack_bit];
      ft_cmd: type_ok = cfg[cmd_bit];
      default: begin
        type_ok = cfg[rsv_bit];
        reserved = 1'b1;
      end
    endcase
  end
endmodule : type_check

// ### src/rx_frame_type_version_filter.sv
// receive frame type and version filter with apb register slave
`timescale 1ns/1ns
module rx_frame_type_version_filter
  import rx_filter_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic frame_start, // pulse: new frame begins
  input wire logic fcf_valid, // pulse: frame control word valid
  input wire logic [15:0] fcf, // frame control word
  input wire logic [6:0] frame_len, // frame length with fcf_valid
  input wire logic addr_match, // address filter passed
  output logic indicate, // pulse: data indication
  output logic ack_request, // pulse: send acknowledgement
  output logic reject, // pulse: frame rejected
  output logic sec_v1_parse // security header uses version 1 layout
);
  logic [7:0] filter_q, filter_d;
  logic [7:0] cfg_q, cfg_d;
  logic indicate_q, indicate_d;
  logic ack_q, ack_d;
  logic reject_q, reject_d;
  logic sec_q, sec_d;
  logic ver_pass, type_ok, reserved, len_ok;
  logic wr_en, rd_en, mapped;
  logic [1:0] fver;

  assign fver = fcf[fcf_ver_lo +: 2];
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign mapped = (paddr == filter_off) || (paddr == status_off);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  version_check u_ver (
    .sel(cfg_q[ver_hi:ver_lo]),
    .ver(fver),
    .pass(ver_pass)
  );

  type_check u_type (
    .cfg(cfg_q),
    .ftype(fcf[fcf_type_lo +: 3]),
    .type_ok(type_ok),
    .reserved(reserved)
  );

  assign len_ok = (frame_len >= len_min) && (frame_len <= len_max);

  always_comb begin
    filter_d = filter_q;
    if (wr_en && paddr == filter_off) begin
      filter_d = pwdata[7:0];
    end
  end

  always_comb begin
    logic normal_ok;
    logic accept;
    normal_ok = 1'b0;
    accept = 1'b0;
    cfg_d = cfg_q;
    indicate_d = 1'b0;
    ack_d = 1'b0;
    reject_d = 1'b0;
    sec_d = sec_q;
    if (frame_start) begin
      cfg_d = filter_q;
    end
    if (fcf_valid) begin
      normal_ok = ver_pass && type_ok && !reserved && addr_match;
      if (cfg_q[rsv_bit]) begin
        accept = len_ok;
      end else begin
        accept = normal_ok;
      end
      // promiscuous indicate ignores address match only
      if (cfg_q[promisc_bit] && !cfg_q[rsv_bit]) begin
        accept = ver_pass && type_ok && !reserved;
      end
      indicate_d = accept;
      // acks only under normal rules; ack frames themselves never acked
      ack_d = accept && normal_ok && fcf[5] && (fcf[2:0] != ft_ack);
      reject_d = !accept;
      sec_d = fcf[fcf_sec_bit] && (fver != 2'h0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_q <= filter_reset;
      cfg_q <= filter_reset;
      indicate_q <= 1'b0;
      ack_q <= 1'b0;
      reject_q <= 1'b0;
      sec_q <= 1'b0;
    end else begin
      filter_q <= filter_d;
      cfg_q <= cfg_d;
      indicate_q <= indicate_d;
      ack_q <= ack_d;
      reject_q <= reject_d;
      sec_q <= sec_d;
    end
  end

  // read data is combinational from flops; apb samples it at the access edge
  always_comb begin
    prdata = 32'h0;
    if (rd_en && paddr == filter_off) begin
      prdata = {24'h0, filter_q};
    end else if (rd_en && paddr == status_off) begin
      prdata = {24'h0, cfg_q};
    end
  end

  assign indicate = indicate_q;
  assign ack_request = ack_q;
  assign reject = reject_q;
  assign sec_v1_parse = sec_q;

  a_rsv_reject: assert property (@(posedge pclk) disable iff (!presetn)
    fcf_valid && reserved && !cfg_q[rsv_bit] |=> reject)
    else $error("reserved type not rejected");
  a_len_only: assert property (@(posedge pclk) disable iff (!presetn)
    fcf_valid && cfg_q[rsv_bit] |=> indicate == $past(len_ok))
    else $error("length only mode wrong");
  a_cmd_off: assert property (@(posedge pclk) disable iff (!presetn)
    fcf_valid && fcf[2:0] == ft_cmd && !cfg_q[cmd_bit] && !cfg_q[rsv_bit]
    |=> reject)
    else $error("command frame passed");
  a_ack_off: assert property (@(posedge pclk) disable iff (!presetn)
    fcf_valid && fcf[2:0] == ft_ack && !cfg_q[ack_bit] && !cfg_q[rsv_bit]
    |=> reject)
    else $error("ack frame passed");
  a_pay_off: assert property (@(posedge pclk) disable iff (!presetn)
    fcf_valid && fcf[2:0] == ft_data && !cfg_q[pay_bit] && !cfg_q[rsv_bit]
    |=> reject)
    else $error("data frame passed");
  a_bcn_off: assert property (@(posedge pclk) disable iff (!presetn)
    fcf_valid && fcf[2:0] == ft_beacon && !cfg_q[bcn_bit] && !cfg_q[rsv_bit]
    |=> reject)
    else $error("beacon frame passed");
  a_ver_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fcf_valid && !cfg_q[rsv_bit] && cfg_q[7:6] == sel_v0 && fver != 2'h0
    |=> reject && !indicate)
    else $error("version selector ignored");
  a_ack_normal: assert property (@(posedge pclk) disable iff (!presetn)
    fcf_valid && !addr_match && !cfg_q[rsv_bit] |=> !ack_request)
    else $error("ack under promiscuous rules");
  a_cfg_sample: assert property (@(posedge pclk) disable iff (!presetn)
    !frame_start |=> cfg_q == $past(cfg_q))
    else $error("settings changed mid frame");
  a_sec_map: assert property (@(posedge pclk) disable iff (!presetn)
    fcf_valid && fcf[fcf_sec_bit] && fver[1] |=> sec_v1_parse)
    else $error("version 2/3 not parsed as 1");
  a_one_out: assert property (@(posedge pclk) disable iff (!presetn)
    !(indicate && reject) && (!ack_request || indicate))
    else $error("outputs inconsistent");

  // both directions of each gate: an enabled frame must not be dropped, a failing one must be rejected
  a_ver_fail: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && !cfg_q[rsv_bit] && !ver_pass |=> reject)
    else $error("failing version accepted");
  a_any_pass: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && !cfg_q[rsv_bit] && cfg_q[7:6] == sel_any && type_ok &&
    !reserved && addr_match |=> indicate)
    else $error("any version selector rejected");
  a_v0_pass: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && !cfg_q[rsv_bit] && cfg_q[7:6] == sel_v0 && fver == 2'h0 &&
    type_ok && !reserved && addr_match |=> indicate)
    else $error("version 0 rejected");
  a_v1_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && !cfg_q[rsv_bit] && cfg_q[7:6] == sel_v1 && fver != 2'h1
    |=> reject)
    else $error("only version 1 selector ignored");
  a_v1_pass: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && !cfg_q[rsv_bit] && cfg_q[7:6] == sel_v1 && fver == 2'h1 &&
    type_ok && !reserved && addr_match |=> indicate)
    else $error("version 1 rejected");
  a_v01_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && !cfg_q[rsv_bit] && cfg_q[7:6] == sel_v01 && fver[1]
    |=> reject)
    else $error("version 2 or 3 accepted");
  a_v01_pass: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && !cfg_q[rsv_bit] && cfg_q[7:6] == sel_v01 && !fver[1] &&
    type_ok && !reserved && addr_match |=> indicate)
    else $error("version 0 or 1 rejected");
  a_sec_v0: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && fver == 2'h0 |=> !sec_v1_parse)
    else $error("version 0 parsed as 1");
  a_sec_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !fcf_valid |=> $stable(sec_v1_parse))
    else $error("security layout changed between frames");
  a_prom_ind: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && cfg_q[promisc_bit] && !cfg_q[rsv_bit] && ver_pass &&
    type_ok && !reserved |=> indicate)
    else $error("promiscuous frame not indicated");
  a_prom_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && !cfg_q[promisc_bit] && !cfg_q[rsv_bit] && !addr_match
    |=> reject)
    else $error("foreign frame indicated");
  a_ack_type: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && fcf[2:0] == ft_ack |=> !ack_request)
    else $error("ack frame acknowledged");
  a_ack_req: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && !fcf[5] |=> !ack_request)
    else $error("ack without request");
  a_rsv_pass: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && cfg_q[rsv_bit] && len_ok |=> indicate)
    else $error("good length rejected");
  a_rsv_len: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && cfg_q[rsv_bit] && !len_ok |=> reject && !ack_request)
    else $error("short frame accepted");
  a_cmd_on: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && fcf[2:0] == ft_cmd && cfg_q[cmd_bit] && ver_pass &&
    addr_match && !cfg_q[rsv_bit] |=> indicate)
    else $error("enabled command frame rejected");
  a_ack_on: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && fcf[2:0] == ft_ack && cfg_q[ack_bit] && ver_pass &&
    addr_match && !cfg_q[rsv_bit] |=> indicate)
    else $error("enabled ack frame rejected");
  a_pay_on: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && fcf[2:0] == ft_data && cfg_q[pay_bit] && ver_pass &&
    addr_match && !cfg_q[rsv_bit] |=> indicate)
    else $error("enabled data frame rejected");
  a_bcn_on: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && fcf[2:0] == ft_beacon && cfg_q[bcn_bit] && ver_pass &&
    addr_match && !cfg_q[rsv_bit] |=> indicate)
    else $error("enabled beacon frame rejected");
  a_rej_noack: assert property (
    @(posedge pclk) disable iff (!presetn)
    fcf_valid && !cfg_q[rsv_bit] && !ver_pass |=> !ack_request)
    else $error("rejected frame acknowledged");
  a_pulse_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    !fcf_valid |=> !indicate && !reject && !ack_request)
    else $error("result without frame");
  a_cfg_take: assert property (
    @(posedge pclk) disable iff (!presetn)
    frame_start |=> cfg_q == $past(filter_q))
    else $error("settings not taken at frame start");
  a_filter_wr: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == filter_off |=> filter_q == $past(pwdata[7:0]))
    else $error("filter write lost");
  a_filter_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_en && paddr == filter_off) |=> $stable(filter_q))
    else $error("filter changed without write");
  a_rd_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    !rd_en |-> prdata == 32'h0)
    else $error("read data outside access");

  c_accept: cover property (@(posedge pclk) disable iff (!presetn)
    indicate && ack_request);
  c_reject: cover property (@(posedge pclk) disable iff (!presetn) reject);
  c_promisc: cover property (@(posedge pclk) disable iff (!presetn)
    indicate && cfg_q[promisc_bit] && !ack_request);
  c_rsv_mode: cover property (@(posedge pclk) disable iff (!presetn)
    indicate && cfg_q[rsv_bit]);
  c_sec_v1: cover property (@(posedge pclk) disable iff (!presetn)
    indicate && sec_v1_parse);
endmodule : rx_frame_type_version_filter

// ### verification/frame_source.sv
// remote node model: presents received frame headers to the filter
`timescale 1ns/1ns
module frame_source (
  input wire logic pclk, // clock
  output logic frame_start, // frame begins
  output logic fcf_valid, // header fields valid
  output logic [15:0] fcf, // frame control word
  output logic [6:0] frame_len, // frame length
  output logic addr_match // address filter result
);
  initial begin
    frame_start = 1'b0;
    fcf_valid = 1'b0;
    fcf = 16'h0000;
    frame_len = 7'h00;
    addr_match = 1'b0;
  end
  task automatic send(input logic [15:0] f, input logic [6:0] n,
                      input logic m);
    @(posedge pclk);
    frame_start <= 1'b1;
    @(posedge pclk);
    frame_start <= 1'b0;
    fcf_valid <= 1'b1;
    fcf <= f;
    frame_len <= n;
    addr_match <= m;
    @(posedge pclk);
    fcf_valid <= 1'b0;
    // fields are stale once the strobe drops, so show junk
    fcf <= ~f;
    frame_len <= ~n;
    addr_match <= ~m;
  endtask : send
endmodule : frame_source

// ### verification/rx_frame_type_version_filter_tb.sv
// bench: register access and frame filtering checks
`timescale 1ns/1ns
module rx_frame_type_version_filter_tb;
  import rx_filter_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, indicate, ack_request, reject;
  logic sec_v1_parse, frame_start, fcf_valid, addr_match, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [15:0] fcf;
  logic [6:0] frame_len;
  int fail_count = 0, comparisons = 0, cyc = 0;
  always #20 pclk = ~pclk;
  frame_source src (.*);
  rx_frame_type_version_filter DUT (.*);
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] x, y);
    comparisons++;
    if (x !== y) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", nm, x, y);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // every version, type, address result and edge length under one setting
  task automatic sweep(input logic [7:0] c);
    logic [15:0] f;
    logic [6:0] n;
    logic vp, tp, nrm, ind;
    apb(1'b1, filter_off, {24'h0, c});
    for (int k = 0; k < 192; k++) begin
      n = (k % 3 == 0) ? 7'h04 : (k % 3 == 1) ? 7'h05 : 7'h7f;
      f = {2'h0, 2'(k / 48), 6'h02, 3'(5 * (k / 3 % 2)), 3'(k / 6 % 8)};
      vp = c[7:6] == 2'h0 || (c[7:6] == 2'h1 && f[13:12] == 2'h0) ||
           (c[7:6] == 2'h2 && f[13:12] == 2'h1) ||
           (c[7:6] == 2'h3 && !f[13]);
      tp = !f[2] && c[f[1:0]];
      nrm = vp && tp && k[0];
      ind = c[4] ? n >= 7'h05 : c[5] ? vp && tp : nrm;
      src.send(f, n, k[0]);
      #1;
      chk("outputs", {ind, ind && nrm && f[5] && f[2:0] != 3'h2, !ind},
          {indicate, ack_request, reject});
      chk("sec_parse", f[3] && f[13:12] != 2'h0, sec_v1_parse);
    end
    $display("sweep %h done", c);
  endtask : sweep
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, filter_off, 32'h0);
    chk("filter_reset", 32'h0f, r);
    apb(1'b1, 12'h044, 32'hff);
    chk("unmapped_err", 1'b1, e);
    apb(1'b0, filter_off, 32'h0);
    chk("filter_kept", 32'h0f, r);
    $display("register test done");
    apb(1'b1, filter_off, 32'h80);
    apb(1'b0, status_off, 32'h0);
    chk("cfg_held", 32'h0f, r);
    src.send(16'h0001, 7'h05, 1'b1);
    apb(1'b0, status_off, 32'h0);
    chk("cfg_taken", 32'h80, r);
    $display("sampling test done");
    sweep(8'h0f);
    sweep(8'h4f);
    sweep(8'h8f);
    sweep(8'hcf);
    sweep(8'h00);
    sweep(8'h01);
    sweep(8'h02);
    sweep(8'h04);
    sweep(8'h08);
    sweep(8'h2f);
    sweep(8'h26);
    sweep(8'h10);
    wrap_up();
  end
endmodule : rx_frame_type_version_filter_tb
